// ===== logic/flow_cal_pkg.sv
// Constants and types for the flow calibration test control block
package flow_cal_pkg;
    localparam int  CLK_HZ            = 100_000_000;
    localparam int  MODE_ENTRY_MS     = 1000;
    localparam int  WARMUP_S          = 16;
    localparam int  PULSE_PERIOD_MS   = 1000;
    localparam int  READ_HOLDOFF_MS   = 2000;
    localparam int  BURST_PAUSE_MS    = 30;
    localparam int  PULSE_WIDTH_MS    = 3;
    localparam int  DEBOUNCE_US       = 100;
    localparam int  VERIFY_SPEEDUP    = 4;
    localparam int  VOL_W             = 32;
    localparam int  FRAC_W            = 16;
    localparam logic [63:0] CYC_PER_MS = 64'(CLK_HZ / 1000);
    localparam logic [63:0] MODE_ENTRY_CYC = 64'(MODE_ENTRY_MS) * CYC_PER_MS;
    localparam logic [63:0] WARMUP_CYC = 64'(WARMUP_S) * 64'(CLK_HZ);
    localparam logic [63:0] PULSE_PERIOD_CYC = 64'(PULSE_PERIOD_MS) * CYC_PER_MS;
    localparam logic [63:0] READ_HOLDOFF_CYC = 64'(READ_HOLDOFF_MS) * CYC_PER_MS;
    localparam logic [63:0] BURST_PAUSE_CYC = 64'(BURST_PAUSE_MS) * CYC_PER_MS;
    localparam logic [63:0] PULSE_WIDTH_CYC = 64'(PULSE_WIDTH_MS) * CYC_PER_MS;
    localparam logic [63:0] DEBOUNCE_CYC = 64'(DEBOUNCE_US) * 64'(CLK_HZ / 1_000_000);
    localparam logic [VOL_W-1:0] VOL_RESET = '0;

    typedef enum logic [2:0] {
        WIN_IDLE    = 3'b000,
        WIN_FIRST   = 3'b001,
        WIN_MIDDLE  = 3'b010,
        WIN_TAIL    = 3'b011,
        WIN_HOLDOFF = 3'b100,
        WIN_READY   = 3'b101
    } win_state_t;
endpackage

// ===== logic/flow_calibration_test_control.sv
// Verification mode entry, gated volume window and pulse emission control
`timescale 1ns/1ps
// Timing counts are cycles of ref_clk_in; the bench shortens them all.
// The volume window only exists in verification mode, and that mode
// is decided once, at the entry point one second after the power-on reset is released.

// Behaviour
// - Verification mode runs measurement routines four times faster.
// - Test line low at power-up enters verification mode after one second.
// - Verification mode stays until power is removed; reset alone clears it.
// - In verification mode, volume accumulates while the test line is low.
// - Window volume is offered for serial readout.
// - Window uses the same interval volumes as pulse computation.
// - Window total corrected for partial intervals at start and stop.
// - First volume scaled by in-window part, middle summed, last extended.
// - Release at window end zeroes the pulse budget; if a pulse is high, its end wraps it to 65535 and pulses go on.
// - Pulse count recomputed once a second, not at window edges.
// - Flow output valid only sixteen seconds after power-up.
// - Pulses computed each second, emitted in bursts with 30 ms pauses.
module flow_calibration_test_control
    import flow_cal_pkg::*;
#(
    parameter logic [63:0] MODE_ENTRY_CYCLES   = MODE_ENTRY_CYC,
    parameter logic [63:0] WARMUP_CYCLES       = WARMUP_CYC,
    parameter logic [63:0] PULSE_PERIOD_CYCLES = PULSE_PERIOD_CYC,
    parameter logic [63:0] READ_HOLDOFF_CYCLES = READ_HOLDOFF_CYC,
    parameter logic [63:0] BURST_PAUSE_CYCLES  = BURST_PAUSE_CYC,
    parameter logic [63:0] PULSE_WIDTH_CYCLES  = PULSE_WIDTH_CYC,
    parameter logic [63:0] DEBOUNCE_CYCLES     = DEBOUNCE_CYC
) (
    input  wire logic              ref_clk_in,
    input  wire logic              reset_in,
    input  wire logic              test_line_n_in,
    input  wire logic              interval_valid_in,
    input  wire logic [VOL_W-1:0]  interval_volume_in,
    input  wire logic [FRAC_W-1:0] interval_pos_in,
    input  wire logic [FRAC_W-1:0] interval_len_in,
    input  wire logic              serial_busy_in,
    output logic                   verify_mode_out,
    output logic [1:0]             meas_rate_div_out,
    output logic                   flow_valid_out,
    output logic                   window_active_out,
    output logic [VOL_W-1:0]       window_volume_out,
    output logic                   window_volume_ready_out,
    output logic                   serial_violation_out,
    output logic                   pulse_out
);
    // Test line synchroniser, three stages
    logic              sync1;
    logic              sync2;
    logic              sync3;

    // Debounced line level and its hold counter
    logic              line_low;
    logic [63:0]       deb_cnt;

    // Power-up timing and mode entry
    logic [63:0]       up_cnt;
    logic              entry_done;
    logic              entry_sampled;
    logic              verify_mode;

    // Window state and accumulator
    win_state_t        state;
    logic [VOL_W-1:0]  acc;
    logic [VOL_W-1:0]  last_vol;
    logic [FRAC_W-1:0] start_pos_hold;
    logic [63:0]       hold_cnt;

    // Once-a-second pulse budget and burst shaping
    logic [63:0]       sec_cnt;
    logic [VOL_W-1:0]  pending_vol;
    logic [15:0]       pulses_left;
    logic [63:0]       pulse_cnt;
    logic              pulse_hi;

    // Partial-interval scaling, shared by start and stop corrections
    function automatic logic [VOL_W-1:0] scale_part(
        input logic [VOL_W-1:0]  vol,
        input logic [FRAC_W-1:0] part,
        input logic [FRAC_W-1:0] total
    );
        logic [VOL_W+FRAC_W-1:0] prod;
        prod = vol * part;
        if (total == '0)
            return vol;
        return VOL_W'(prod / total);
    endfunction

    // Edge qualification: second and third stage agree, hold time met
    wire agree       = (sync2 == sync3);
    wire raw_low     = ~sync3;
    wire deb_done    = (deb_cnt >= DEBOUNCE_CYCLES - 64'd1);
    wire fall_evt    = agree && raw_low && !line_low && deb_done;
    wire rise_evt    = agree && !raw_low && line_low && deb_done;
    wire sec_tick    = (sec_cnt == PULSE_PERIOD_CYCLES - 64'd1);
    wire entry_point = !entry_done && (up_cnt == MODE_ENTRY_CYCLES - 64'd1);
    wire width_end   = pulse_hi && (pulse_cnt == PULSE_WIDTH_CYCLES - 64'd1);
    wire pause_run   = !pulse_hi && (pulse_cnt < BURST_PAUSE_CYCLES - 64'd1);
    wire cut_evt     = rise_evt && verify_mode && window_active_out;

    // Start fraction is taken at the opening edge, stop at the closing one
    wire [FRAC_W-1:0] start_interval_pre_fraction = start_pos_hold;
    wire [FRAC_W-1:0] stop_interval_post_fraction = interval_pos_in;
    wire [FRAC_W-1:0] in_window_part =
        interval_len_in - start_interval_pre_fraction;
    wire [FRAC_W-1:0] start_in_window =
        (start_interval_pre_fraction > interval_len_in) ? '0 : in_window_part;

    // An interval ending on the stop edge still belongs to the window, except in WIN_FIRST
    wire [VOL_W-1:0]  interval_add =
        interval_valid_in ? interval_volume_in : VOL_RESET;
    wire [VOL_W-1:0]  pending_base = sec_tick ? VOL_RESET : pending_vol;

    // No reset: the debounce ignores the stages until they agree
    always_ff @(posedge ref_clk_in) begin
        sync1 <= test_line_n_in;
        sync2 <= sync1;
        sync3 <= sync2;
    end

    // Debounce: a change counts after stable agreement for the hold time
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            deb_cnt  <= '0;
            line_low <= 1'b0;
        end else if (!agree || (raw_low == line_low)) begin
            deb_cnt <= '0;
        end else if (deb_done) begin
            deb_cnt  <= '0;
            line_low <= raw_low;
        end else begin
            deb_cnt <= deb_cnt + 64'd1;
        end
    end

    // Power-up timer; reset stands for power-on here
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            up_cnt <= '0;
        end else if (up_cnt != WARMUP_CYCLES) begin
            up_cnt <= up_cnt + 64'd1;
        end
    end

    // Line must be low from power-up until the entry point
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            entry_sampled <= 1'b0;
            entry_done    <= 1'b0;
        end else begin
            if (!entry_sampled && up_cnt == 64'd2)
                entry_sampled <= 1'b1;
            if (entry_sampled && !entry_done && !line_low
                && up_cnt > DEBOUNCE_CYCLES + 64'd8)
                entry_done <= 1'b1;
            if (entry_point)
                entry_done <= 1'b1;
        end
    end

    // Sticky: nothing clears it short of power loss
    always_ff @(posedge ref_clk_in) begin
        if (reset_in)
            verify_mode <= 1'b0;
        else if (entry_point)
            verify_mode <= line_low;
        else
            verify_mode <= verify_mode;
    end

    assign verify_mode_out   = verify_mode;
    assign meas_rate_div_out = verify_mode ? 2'(VERIFY_SPEEDUP - 1) : 2'd0;
    assign flow_valid_out    = (up_cnt == WARMUP_CYCLES);

    // Window: ignore the entry grounding, whose falling edge comes before mode entry
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            state          <= WIN_IDLE;
            acc            <= VOL_RESET;
            last_vol       <= VOL_RESET;
            start_pos_hold <= '0;
            hold_cnt       <= '0;
        end else begin
            case (state)
                WIN_IDLE, WIN_READY: begin
                    if (verify_mode && fall_evt) begin
                        state          <= WIN_FIRST;
                        acc            <= VOL_RESET;
                        // Time already elapsed in the open interval
                        start_pos_hold <= interval_pos_in;
                    end
                end
                WIN_FIRST: begin
                    if (rise_evt) begin
                        state <= WIN_HOLDOFF;
                        hold_cnt <= '0;
                    end else if (interval_valid_in) begin
                        acc <= scale_part(interval_volume_in,
                                          start_in_window,
                                          interval_len_in);
                        last_vol <= interval_volume_in;
                        state <= WIN_MIDDLE;
                    end
                end
                WIN_MIDDLE: begin
                    if (rise_evt) begin
                        acc <= acc + interval_add
                                   + scale_part(last_vol,
                                                stop_interval_post_fraction,
                                                interval_len_in);
                        state    <= WIN_HOLDOFF;
                        hold_cnt <= '0;
                    end else if (interval_valid_in) begin
                        acc      <= acc + interval_volume_in;
                        last_vol <= interval_volume_in;
                    end
                end
                WIN_HOLDOFF: begin
                    hold_cnt <= hold_cnt + 64'd1;
                    if (hold_cnt == READ_HOLDOFF_CYCLES - 64'd1)
                        state <= WIN_READY;
                end
                default: state <= WIN_IDLE;
            endcase
        end
    end

    assign window_active_out       = (state == WIN_FIRST) ||
                                     (state == WIN_MIDDLE);
    assign window_volume_out       = acc;
    assign window_volume_ready_out = (state == WIN_READY);
    assign serial_violation_out    = window_active_out && serial_busy_in;

    // Volume summed over each second feeds the pulse budget
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            sec_cnt     <= '0;
            pending_vol <= VOL_RESET;
        end else begin
            sec_cnt     <= sec_tick ? 64'd0 : sec_cnt + 64'd1;
            pending_vol <= pending_base + interval_add;
        end
    end

    // Budget fixed at the second tick only; the window close wins
    always_ff @(posedge ref_clk_in) begin
        if (reset_in)
            pulses_left <= '0;
        else if (cut_evt)
            pulses_left <= '0;
        else if (sec_tick && flow_valid_out)
            pulses_left <= pending_vol[15:0];
        else if (width_end)
            pulses_left <= pulses_left - 16'd1;
    end

    // Burst shaping: fixed width, then a pause before the next pulse
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            pulse_cnt <= '0;
            pulse_hi  <= 1'b0;
        end else if (width_end) begin
            pulse_hi  <= 1'b0;
            pulse_cnt <= '0;
        end else if (pulse_hi || pause_run) begin
            pulse_cnt <= pulse_cnt + 64'd1;
        end else if (pulses_left != 16'd0 && !rise_evt) begin
            pulse_hi  <= 1'b1;
            pulse_cnt <= '0;
        end
    end

    // A pulse already started is finished, never cut short

    assign pulse_out = pulse_hi;
endmodule

// ===== verif/flow_cal_checker_assertions.sv
// Port-level checks for the calibration test control block
`timescale 1ns/1ps
module flow_cal_checker
    import flow_cal_pkg::*;
(
    input wire logic             ref_clk_in,
    input wire logic             reset_in,
    input wire logic             test_line_n_in,
    input wire logic             serial_busy_in,
    input wire logic             verify_mode_out,
    input wire logic [1:0]       meas_rate_div_out,
    input wire logic             flow_valid_out,
    input wire logic             window_active_out,
    input wire logic [VOL_W-1:0] window_volume_out,
    input wire logic             window_volume_ready_out,
    input wire logic             serial_violation_out,
    input wire logic             pulse_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    AST_RATE_DIV: assert property (meas_rate_div_out ==
        (verify_mode_out ? 2'h3 : 2'h0)) else $error("rate divider wrong");
    AST_MODE_STICKY: assert property (verify_mode_out |=>
        verify_mode_out) else $error("verification mode left");
    AST_WIN_MODE: assert property (window_active_out |->
        verify_mode_out) else $error("window outside mode");
    AST_WIN_OPEN: assert property ($rose(window_active_out) |->
        $past(test_line_n_in, 3) == 1'b0) else $error("window open early");
    AST_WIN_CLOSE: assert property ($fell(window_active_out) |->
        $past(test_line_n_in, 3) == 1'b1) else $error("window shut early");
    AST_READY_HOLD: assert property ($fell(window_active_out) |->
        !window_volume_ready_out [*8]) else $error("ready too soon");
    AST_READY_GAP: assert property (window_volume_ready_out |->
        !window_active_out) else $error("ready in window");
    AST_VOL_STABLE: assert property (window_volume_ready_out &&
        $past(window_volume_ready_out) |-> $stable(window_volume_out))
        else $error("volume moved");
    AST_SER_FLAG: assert property (serial_busy_in &&
        window_active_out |-> ##[0:2] serial_violation_out)
        else $error("serial traffic not flagged");
    AST_PULSE_CUT: assert property ($fell(window_active_out) |->
        ##[1:4] !pulse_out [*4]) else $error("pulses after window");
    AST_FLOW_KEEP: assert property (flow_valid_out |=>
        flow_valid_out) else $error("flow valid dropped");
endmodule
bind flow_calibration_test_control flow_cal_checker u_flow_cal_checker (
    .ref_clk_in, .reset_in, .test_line_n_in, .serial_busy_in,
    .verify_mode_out, .meas_rate_div_out, .flow_valid_out,
    .window_active_out, .window_volume_out, .window_volume_ready_out,
    .serial_violation_out, .pulse_out
);

// ===== verif/cal_rig_model.sv
// Calibration rig model: interval source, test line and serial reader
`timescale 1ns/1ps
module cal_rig_model
    import flow_cal_pkg::*;
(
    input  wire logic          clk_in,
    input  wire logic          reset_in,
    output logic               test_line_n_out,
    output logic               serial_busy_out,
    output logic               interval_valid_out,
    output logic [VOL_W-1:0]   interval_volume_out,
    output logic [FRAC_W-1:0]  interval_pos_out,
    output logic [FRAC_W-1:0]  interval_len_out
);
    logic [5:0] tick = '0;
    initial test_line_n_out = 1'b1;
    initial serial_busy_out = 1'b0;
    // 400 per 50-cycle interval: the exact window total is 8 per cycle
    assign interval_volume_out = 32'h190;
    // Position is the time since the last sample, in clock cycles
    assign interval_pos_out    = {10'h000, tick};
    assign interval_len_out    = 16'h32;
    assign interval_valid_out  = (tick == 6'h00) && !reset_in;
    always @(negedge clk_in) begin
        tick <= (reset_in || tick == 6'h31) ? 6'h00 : tick + 6'h01;
    end
    task automatic set_line(input logic v);
        test_line_n_out = v;
    endtask
    task automatic set_busy(input logic v);
        serial_busy_out = v;
    endtask
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the calibration test control block
`timescale 1ns/1ps
module tb_top
    import flow_cal_pkg::*;
;
    logic             ref_clk_in, reset_in;
    logic             line_n, busy, ivalid;
    logic [VOL_W-1:0] ivol, vol;
    logic [FRAC_W-1:0] ipos, ilen;
    logic             verify, fvalid, active, ready, viol, pulse;
    logic [1:0]       div;
    int               fail_count = 0;
    int               checks = 0;
    int               low_cnt = 0;
    int               mark = 0;
    localparam int    VOL_PER_CYC = 8;
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    cal_rig_model u_cal_rig_model (.clk_in(ref_clk_in), .reset_in(reset_in),
        .test_line_n_out(line_n), .serial_busy_out(busy),
        .interval_valid_out(ivalid), .interval_volume_out(ivol),
        .interval_pos_out(ipos), .interval_len_out(ilen));
    flow_calibration_test_control #(.MODE_ENTRY_CYCLES(64'd200),
        .WARMUP_CYCLES(64'd500), .PULSE_PERIOD_CYCLES(64'd300),
        .READ_HOLDOFF_CYCLES(64'd100), .BURST_PAUSE_CYCLES(64'd10),
        .PULSE_WIDTH_CYCLES(64'd3), .DEBOUNCE_CYCLES(64'd4)
    ) u_flow_calibration_test_control (.ref_clk_in(ref_clk_in),
        .reset_in(reset_in), .test_line_n_in(line_n),
        .interval_valid_in(ivalid), .interval_volume_in(ivol),
        .interval_pos_in(ipos), .interval_len_in(ilen),
        .serial_busy_in(busy), .verify_mode_out(verify),
        .meas_rate_div_out(div), .flow_valid_out(fvalid),
        .window_active_out(active), .window_volume_out(vol),
        .window_volume_ready_out(ready), .serial_violation_out(viol),
        .pulse_out(pulse));
    // Cycles with the test line grounded, as the design will see them
    always @(posedge ref_clk_in) if (!line_n) low_cnt <= low_cnt + 1;
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(negedge ref_clk_in);
    endtask
    task automatic power_up(input logic line);
        step(1);
        reset_in = 1'b1;
        u_cal_rig_model.set_line(line);
        step(6);
        reset_in = 1'b0;
    endtask
    // Bounded wait; the caller judges whether the level was reached
    task automatic wait_active(input logic lvl);
        for (int i = 0; i < 30 && active !== lvl; i++) step(1);
    endtask
    task automatic normal_mode_test();
        power_up(1'b1);
        step(250);
        check("verify", verify, 1'b0);
        check("div", div, 2'h0);
        u_cal_rig_model.set_line(1'b0);
        step(100);
        check("active", active, 1'b0);
        check("flow_valid", fvalid, 1'b0);
        check("pulse", pulse, 1'b0);
        u_cal_rig_model.set_line(1'b1);
        step(200);
        check("flow_valid", fvalid, 1'b1);
        for (int i = 0; i < 400 && pulse !== 1'b1; i++) step(1);
        check("pulse", pulse, 1'b1);
    endtask
    task automatic window_test();
        power_up(1'b0);
        step(250);
        check("verify", verify, 1'b1);
        check("div", div, 2'h3);
        u_cal_rig_model.set_line(1'b1);
        // Let the release debounce before grounding again
        step(20);
        @(posedge ivalid);
        step(1);
        mark = low_cnt;
        u_cal_rig_model.set_line(1'b0);
        wait_active(1'b1);
        check("active", active, 1'b1);
        step(120);
        u_cal_rig_model.set_busy(1'b1);
        step(2);
        check("violation", viol, 1'b1);
        u_cal_rig_model.set_busy(1'b0);
        step(1);
        check("violation", viol, 1'b0);
        @(posedge ivalid);
        step(1);
        u_cal_rig_model.set_line(1'b1);
        mark = low_cnt - mark;
        wait_active(1'b0);
        check("active", active, 1'b0);
        check("ready", ready, 1'b0);
        step(110);
        check("ready", ready, 1'b1);
        check("volume", vol, 32'(mark * VOL_PER_CYC));
        check("verify", verify, 1'b1);
    endtask
    task automatic print_verdict();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        reset_in = 1'b1;
        normal_mode_test();
        window_test();
        print_verdict();
    end
    initial begin
        #500000;
        fail_count++;
        print_verdict();
    end
endmodule
